// ---- shared/fa_pkg.sv ----
// Package with register map, field positions, timing and carrier types.
package fa_pkg;

  localparam logic [7:0] OFF_LDO_PROT_CFG   = 8'h01;
  localparam logic [7:0] OFF_FAULT_FLAGS    = 8'h05;
  localparam logic [7:0] OFF_LDO_SOURCE     = 8'h0B;
  localparam logic [7:0] OFF_CONV_OPTIONS   = 8'h10;
  localparam logic [7:0] OFF_LDO_VOLTAGE    = 8'h11;
  localparam logic [7:0] OFF_ALERT_MASK_A   = 8'h1E;
  localparam logic [7:0] OFF_ALERT_MASK_B   = 8'h1F;
  localparam logic [7:0] OFF_ALERT_MASK_C   = 8'h20;

  localparam logic [7:0] RST_LDO_PROT_CFG   = 8'h00;
  localparam logic [7:0] RST_LDO_SOURCE     = 8'h00;
  localparam logic [7:0] RST_CONV_OPTIONS   = 8'h00;
  localparam logic [7:0] RST_LDO_VOLTAGE    = 8'h0D;
  localparam logic [7:0] RST_ALERT_MASK     = 8'h00;

  localparam int BIT_AUX_LDO_OFF            = 0;
  localparam int BIT_FLT_AUX_LDO            = 0;
  localparam int BIT_FLT_THERMAL            = 1;
  localparam int BIT_FLT_FET_OC             = 2;
  localparam int BIT_FLT_WATCHDOG           = 3;
  localparam int BIT_FLT_VIN_OV             = 4;
  localparam int BIT_FLT_VIN_UV             = 5;
  localparam int BIT_ALERT_CLEAR            = 7;
  localparam int BIT_LDO_SOURCE_MANUAL      = 0;
  localparam int BIT_LDO_SOURCE_PICK        = 1;
  localparam int BIT_SKIP_MODE_OFF          = 0;
  localparam int BIT_AUX_FAULT_IGNORE       = 1;
  localparam int LDO_VOLTAGE_BITS           = 5;

  localparam int NUM_SRC                    = 11;
  localparam int SRC_WATCHDOG               = 0;
  localparam int SRC_AUX_LDO                = 1;
  localparam int SRC_THERMAL                = 2;
  localparam int SRC_FET_OC                 = 3;
  localparam int SRC_ADC_DONE               = 4;
  localparam int SRC_STANDBY                = 5;
  localparam int SRC_BUS_TIMEOUT            = 6;
  localparam int SRC_VIN_OV                 = 7;
  localparam int SRC_VIN_UV                 = 8;
  localparam int SRC_LIGHT_LOAD             = 9;
  localparam int SRC_HICCUP                 = 10;
  localparam logic [NUM_SRC-1:0] LEVEL_SRC  = 11'h18F;

  localparam int CLK_PERIOD_NS              = 10;
  localparam int T_LDO_ILIM_NS              = 90000;
  localparam int T_LDO_OFF_MS               = 100;
  localparam int T_BUS_TIMEOUT_MS           = 100;
  localparam int LDO_ILIM_CYC =
    (T_LDO_ILIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LDO_OFF_CYC  = T_LDO_OFF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BUS_TMO_CYC  = T_BUS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W                      = 24;

  // Arbitrary 7-bit bus address of this device.
  localparam logic [6:0] BUS_ADDR_DEFAULT   = 7'h2A;

  typedef struct packed {
    logic scl;
    logic sda;
    logic en;
    logic wdt_expired;
    logic ldo_ilim;
    logic ldo_uv;
    logic thermal_over;
    logic fet_oc;
    logic adc_done;
    logic adc_enabled;
    logic vin_ov;
    logic vin_uv;
    logic light_load_off_state;
    logic hiccup_state;
    logic vin_lower;
    logic low_headroom;
  } fa_pins_s;

  localparam fa_pins_s PINS_IDLE = '{scl: 1'b1, sda: 1'b1, default: 1'b0};

  typedef enum logic {
    PS_STANDBY,
    PS_POWER_ON
  } fa_power_e;

  typedef enum logic [1:0] {
    LS_RUN,
    LS_OFF_WAIT
  } fa_ldo_e;

  typedef enum logic [3:0] {
    BS_IDLE,
    BS_ADDR,
    BS_ADDR_ACK,
    BS_PTR,
    BS_PTR_ACK,
    BS_WDATA,
    BS_WDATA_ACK,
    BS_RDATA,
    BS_RACK
  } fa_bus_e;

endpackage

// ---- src/fa_supervisor.sv ----
// Fault alert supervisor with serial register slave and LDO retry control.
`timescale 1ns/1ps
// What this block does
// - Each alert source has its own mask bit over three mask registers.
// - Writing 1 to alert-clear releases alerts whose release condition holds.
// - Alert-clear bit self-clears and always reads back zero.
// - Watchdog expiry is a level source; needs reset plus clear write.
// - LDO fault is level; held through regulation loss and shutdown wait.
// - Thermal trip is level; releases only once cool and cleared.
// - Switch overcurrent latches until standby entry plus clear write.
// - ADC conversion done while enabled sets an edge alert.
// - Every standby entry sets an edge alert.
// - Bus command longer than 100ms start to stop raises edge alert.
// - Timeout discards partial data; timer restarts on each start.
// - Input overvoltage is a level source, cleared once gone.
// - Input undervoltage is level; releases once back in range.
// - Light-load off entry sets edge alert, clearable while staying.
// - Hiccup entry sets edge alert released by a clear write.
// - LDO in limit over 90us is shut off 100ms, then retried.
// - LDO limit timeout or undervoltage stops converter switching.
// - Fault-ignore bit keeps converter running through LDO faults.
// - LDO fault stops converter unless fault-ignore is set, and always sets the LDO fault flag.
// - LDO source: lower supply automatically (the other one at low headroom), or manual pick output/input.
// - Starts in standby with defaults; goes to power-on when enabled.
// - A status change drives the alert low unless masked.
// - Thermal flag latches until the host reads it.
module fa_supervisor
  import fa_pkg::*;
#(
  parameter logic [6:0]  BUS_ADDR  = BUS_ADDR_DEFAULT,
  parameter int unsigned ILIM_CYC  = LDO_ILIM_CYC,
  parameter int unsigned OFF_CYC   = LDO_OFF_CYC,
  parameter int unsigned TMO_CYC   = BUS_TMO_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  input  wire fa_pins_s                    i_pins,
  output logic                             o_sda_oe,
  output logic                             o_fault_alert_oe,
  output logic                             o_aux_ldo_off,
  output logic                             o_ldo_src_vin,
  output logic                             o_conv_stop,
  output logic                             o_standby_state,
  output logic                             o_skip_mode_off,
  output logic [LDO_VOLTAGE_BITS-1:0]      o_ldo_vsel
);

  fa_pins_s             meta_q;
  fa_pins_s             pin_q;
  fa_pins_s             prev_q;
  fa_power_e            pwr_q;
  fa_ldo_e              ldo_q;
  fa_bus_e              bus_q;
  logic [CNT_W-1:0]     ldo_cnt_q;
  logic [CNT_W-1:0]     tmo_cnt_q;
  logic                 tmo_busy_q;
  logic                 tmo_pulse_q;
  logic [7:0]           cfg_q;
  logic [7:0]           src_q;
  logic [7:0]           opt_q;
  logic [7:0]           vset_q;
  logic [7:0]           mask_a_q;
  logic [7:0]           mask_b_q;
  logic [7:0]           mask_c_q;
  logic [NUM_SRC-1:0]   pend_q;
  logic [NUM_SRC-1:0]   pend_d;
  logic                 fet_latch_q;
  logic                 therm_latch_q;
  logic                 stby_entry_q;
  logic [7:0]           shreg_q;
  logic [3:0]           bitcnt_q;
  logic [7:0]           ptr_q;
  logic                 rnw_q;
  logic                 nack_q;
  logic                 wr_q;
  logic [7:0]           wdata_q;
  logic                 rd_q;
  logic [7:0]           rd_ptr_q;

  function automatic logic [7:0] reg_read(
    input logic [7:0]         addr,
    input logic [7:0]         flags,
    input logic [7:0]         cfg,
    input logic [7:0]         src,
    input logic [7:0]         opt,
    input logic [7:0]         vset,
    input logic [23:0]        masks
  );
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      OFF_LDO_PROT_CFG: v = cfg;
      OFF_FAULT_FLAGS:  v = flags;
      OFF_LDO_SOURCE:   v = src;
      OFF_CONV_OPTIONS: v = opt;
      OFF_LDO_VOLTAGE:  v = vset;
      OFF_ALERT_MASK_A: v = masks[7:0];
      OFF_ALERT_MASK_B: v = masks[15:8];
      OFF_ALERT_MASK_C: v = masks[23:16];
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // Bus line conditions seen through the synchronised pins.
  wire scl_rise  = pin_q.scl & ~prev_q.scl;
  wire scl_fall  = ~pin_q.scl & prev_q.scl;
  wire bus_start = pin_q.scl & prev_q.scl & prev_q.sda & ~pin_q.sda;
  wire bus_stop  = pin_q.scl & prev_q.scl & ~prev_q.sda & pin_q.sda;
  wire byte_done = bitcnt_q == 4'h8;

  wire wr_hit_cfg   = wr_q & (ptr_q == OFF_LDO_PROT_CFG);
  wire wr_hit_src   = wr_q & (ptr_q == OFF_LDO_SOURCE);
  wire wr_hit_opt   = wr_q & (ptr_q == OFF_CONV_OPTIONS);
  wire wr_hit_vset  = wr_q & (ptr_q == OFF_LDO_VOLTAGE);
  wire wr_hit_mask_a = wr_q & (ptr_q == OFF_ALERT_MASK_A);
  wire wr_hit_mask_b = wr_q & (ptr_q == OFF_ALERT_MASK_B);
  wire wr_hit_mask_c = wr_q & (ptr_q == OFF_ALERT_MASK_C);
  wire alert_clear  = wr_q & (ptr_q == OFF_FAULT_FLAGS) &
                      wdata_q[BIT_ALERT_CLEAR];
  wire flags_read   = rd_q & (rd_ptr_q == OFF_FAULT_FLAGS);

  wire fault_ignore = opt_q[BIT_AUX_FAULT_IGNORE];
  wire ldo_waiting  = ldo_q == LS_OFF_WAIT;
  wire ldo_bad      = pin_q.ldo_uv | pin_q.ldo_ilim | ldo_waiting;

  wire [NUM_SRC-1:0] mask_vec = {mask_c_q[2:0], mask_b_q[3:0],
                                 mask_a_q[3:0]};

  // Level sources stay active while their condition holds.
  wire [NUM_SRC-1:0] level_now;
  assign level_now[SRC_WATCHDOG]    = pin_q.wdt_expired;
  assign level_now[SRC_AUX_LDO]     = ldo_bad;
  assign level_now[SRC_THERMAL]     = pin_q.thermal_over;
  assign level_now[SRC_FET_OC]      = fet_latch_q;
  assign level_now[SRC_ADC_DONE]    = 1'b0;
  assign level_now[SRC_STANDBY]     = 1'b0;
  assign level_now[SRC_BUS_TIMEOUT] = 1'b0;
  assign level_now[SRC_VIN_OV]      = pin_q.vin_ov;
  assign level_now[SRC_VIN_UV]      = pin_q.vin_uv;
  assign level_now[SRC_LIGHT_LOAD]  = 1'b0;
  assign level_now[SRC_HICCUP]      = 1'b0;

  // Edge sources fire once per entry into their event.
  wire [NUM_SRC-1:0] edge_now;
  assign edge_now[SRC_WATCHDOG]    = 1'b0;
  assign edge_now[SRC_AUX_LDO]     = 1'b0;
  assign edge_now[SRC_THERMAL]     = 1'b0;
  assign edge_now[SRC_FET_OC]      = 1'b0;
  assign edge_now[SRC_ADC_DONE]    = pin_q.adc_done & ~prev_q.adc_done &
                                     pin_q.adc_enabled;
  assign edge_now[SRC_STANDBY]     = stby_entry_q;
  assign edge_now[SRC_BUS_TIMEOUT] = tmo_pulse_q;
  assign edge_now[SRC_VIN_OV]      = 1'b0;
  assign edge_now[SRC_VIN_UV]      = 1'b0;
  assign edge_now[SRC_LIGHT_LOAD]  = pin_q.light_load_off_state &
                                     ~prev_q.light_load_off_state;
  assign edge_now[SRC_HICCUP]      = pin_q.hiccup_state &
                                     ~prev_q.hiccup_state;

  // A new event wins over a clear in the same cycle.
  assign pend_d = level_now | edge_now |
                  (alert_clear ? '0 : pend_q);

  wire [7:0] flags_rd;
  assign flags_rd[BIT_FLT_AUX_LDO]  = pend_q[SRC_AUX_LDO];
  assign flags_rd[BIT_FLT_THERMAL]  = therm_latch_q;
  assign flags_rd[BIT_FLT_FET_OC]   = fet_latch_q;
  assign flags_rd[BIT_FLT_WATCHDOG] = pin_q.wdt_expired;
  assign flags_rd[BIT_FLT_VIN_OV]   = pin_q.vin_ov;
  assign flags_rd[BIT_FLT_VIN_UV]   = pin_q.vin_uv;
  assign flags_rd[6]                = 1'b0;
  assign flags_rd[BIT_ALERT_CLEAR]  = 1'b0;

  wire [7:0] rd_val = reg_read(ptr_q, flags_rd, cfg_q, src_q, opt_q,
                               vset_q, {mask_c_q, mask_b_q, mask_a_q});

  wire auto_src_vin = pin_q.vin_lower ^ pin_q.low_headroom;
  wire src_vin_d    = src_q[BIT_LDO_SOURCE_MANUAL] ?
                      src_q[BIT_LDO_SOURCE_PICK] : auto_src_vin;
  wire ldo_trip     = (ldo_q == LS_RUN) & pin_q.ldo_ilim &
                      (ldo_cnt_q == CNT_W'(ILIM_CYC - 1));
  wire conv_stop_d  = ~fault_ignore & (ldo_waiting | ldo_trip |
                      pin_q.ldo_uv);
  wire tmo_hit      = tmo_busy_q & ~bus_start & ~bus_stop &
                      (tmo_cnt_q == CNT_W'(TMO_CYC - 1));

  // Outside pins pass two flip-flops before use.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= PINS_IDLE;
      pin_q  <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else begin
      meta_q <= i_pins;
      pin_q  <= meta_q;
      prev_q <= pin_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_q    <= RST_LDO_PROT_CFG;
      src_q    <= RST_LDO_SOURCE;
      opt_q    <= RST_CONV_OPTIONS;
      vset_q   <= RST_LDO_VOLTAGE;
      mask_a_q <= RST_ALERT_MASK;
      mask_b_q <= RST_ALERT_MASK;
      mask_c_q <= RST_ALERT_MASK;
    end else begin
      if (wr_hit_cfg)    cfg_q    <= wdata_q;
      if (wr_hit_src)    src_q    <= wdata_q;
      if (wr_hit_opt)    opt_q    <= wdata_q;
      if (wr_hit_vset)   vset_q   <= wdata_q;
      if (wr_hit_mask_a) mask_a_q <= wdata_q;
      if (wr_hit_mask_b) mask_b_q <= wdata_q;
      if (wr_hit_mask_c) mask_c_q <= wdata_q;
    end
  end

  // Pending flags, latches and the registered open-drain alert drive.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_q           <= '0;
      fet_latch_q      <= 1'b0;
      therm_latch_q    <= 1'b0;
      o_fault_alert_oe <= 1'b0;
    end else begin
      pend_q           <= pend_d;
      o_fault_alert_oe <= |(pend_d & ~mask_vec);
      fet_latch_q      <= pin_q.fet_oc |
                          (fet_latch_q & ~(pwr_q == PS_STANDBY));
      therm_latch_q    <= pin_q.thermal_over |
                          (therm_latch_q & ~flags_read);
    end
  end

  // Standby and power-on states.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_q        <= PS_STANDBY;
      stby_entry_q <= 1'b0;
    end else begin
      stby_entry_q <= 1'b0;
      case (pwr_q)
        PS_STANDBY:  if (pin_q.en) pwr_q <= PS_POWER_ON;
        PS_POWER_ON: begin
          if (!pin_q.en) begin
            pwr_q        <= PS_STANDBY;
            stby_entry_q <= 1'b1;
          end
        end
        default:     pwr_q <= PS_STANDBY;
      endcase
    end
  end

  // LDO current-limit timer and shutdown retry cycle.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ldo_q     <= LS_RUN;
      ldo_cnt_q <= '0;
    end else begin
      case (ldo_q)
        LS_RUN: begin
          if (!pin_q.ldo_ilim) begin
            ldo_cnt_q <= '0;
          end else if (ldo_trip) begin
            ldo_q     <= LS_OFF_WAIT;
            ldo_cnt_q <= '0;
          end else begin
            ldo_cnt_q <= ldo_cnt_q + 1'b1;
          end
        end
        LS_OFF_WAIT: begin
          if (ldo_cnt_q == CNT_W'(OFF_CYC - 1)) begin
            ldo_q     <= LS_RUN;
            ldo_cnt_q <= '0;
          end else begin
            ldo_cnt_q <= ldo_cnt_q + 1'b1;
          end
        end
        default: begin
          ldo_q     <= LS_RUN;
          ldo_cnt_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_aux_ldo_off   <= 1'b0;
      o_ldo_src_vin   <= 1'b0;
      o_conv_stop     <= 1'b0;
      o_standby_state <= 1'b1;
      o_skip_mode_off <= 1'b0;
      o_ldo_vsel      <= '0;
    end else begin
      o_aux_ldo_off   <= cfg_q[BIT_AUX_LDO_OFF] | ldo_waiting;
      o_ldo_src_vin   <= src_vin_d;
      o_conv_stop     <= conv_stop_d;
      o_standby_state <= pwr_q == PS_STANDBY;
      o_skip_mode_off <= opt_q[BIT_SKIP_MODE_OFF];
      o_ldo_vsel      <= vset_q[LDO_VOLTAGE_BITS-1:0];
    end
  end

  // Command timer runs from each start to the matching stop.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmo_busy_q  <= 1'b0;
      tmo_cnt_q   <= '0;
      tmo_pulse_q <= 1'b0;
    end else begin
      tmo_pulse_q <= tmo_hit;
      if (bus_start) begin
        tmo_busy_q <= 1'b1;
        tmo_cnt_q  <= '0;
      end else if (bus_stop || tmo_hit) begin
        tmo_busy_q <= 1'b0;
        tmo_cnt_q  <= '0;
      end else if (tmo_busy_q) begin
        tmo_cnt_q  <= tmo_cnt_q + 1'b1;
      end
    end
  end

  // Serial register slave: address, pointer, then data bytes.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_q    <= BS_IDLE;
      shreg_q  <= '0;
      bitcnt_q <= '0;
      ptr_q    <= '0;
      rnw_q    <= 1'b0;
      nack_q   <= 1'b0;
      wr_q     <= 1'b0;
      wdata_q  <= '0;
      rd_q     <= 1'b0;
      rd_ptr_q <= '0;
      o_sda_oe <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      if (tmo_hit || bus_stop) begin
        bus_q    <= BS_IDLE;
        bitcnt_q <= '0;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        bus_q    <= BS_ADDR;
        bitcnt_q <= '0;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (bus_q)
          BS_ADDR, BS_PTR, BS_WDATA: begin
            shreg_q  <= {shreg_q[6:0], pin_q.sda};
            bitcnt_q <= bitcnt_q + 1'b1;
          end
          BS_RDATA: bitcnt_q <= bitcnt_q + 1'b1;
          BS_RACK:  nack_q   <= pin_q.sda;
          default:  nack_q   <= nack_q;
        endcase
      end else if (scl_fall) begin
        case (bus_q)
          BS_ADDR: begin
            if (byte_done && shreg_q[7:1] == BUS_ADDR) begin
              bus_q    <= BS_ADDR_ACK;
              rnw_q    <= shreg_q[0];
              o_sda_oe <= 1'b1;
            end else if (byte_done) begin
              bus_q    <= BS_IDLE;
            end
          end
          BS_PTR: begin
            if (byte_done) begin
              ptr_q    <= shreg_q;
              bus_q    <= BS_PTR_ACK;
              o_sda_oe <= 1'b1;
            end
          end
          BS_WDATA: begin
            if (byte_done) begin
              wr_q     <= 1'b1;
              wdata_q  <= shreg_q;
              bus_q    <= BS_WDATA_ACK;
              o_sda_oe <= 1'b1;
            end
          end
          BS_ADDR_ACK, BS_RACK: begin
            bitcnt_q <= '0;
            if (bus_q == BS_RACK && nack_q) begin
              bus_q    <= BS_IDLE;
              o_sda_oe <= 1'b0;
            end else if (bus_q == BS_RACK || rnw_q) begin
              shreg_q  <= rd_val;
              rd_q     <= 1'b1;
              rd_ptr_q <= ptr_q;
              bus_q    <= BS_RDATA;
              o_sda_oe <= ~rd_val[7];
            end else begin
              bus_q    <= BS_PTR;
              o_sda_oe <= 1'b0;
            end
          end
          BS_PTR_ACK, BS_WDATA_ACK: begin
            if (bus_q == BS_WDATA_ACK) ptr_q <= ptr_q + 1'b1;
            bitcnt_q <= '0;
            bus_q    <= BS_WDATA;
            o_sda_oe <= 1'b0;
          end
          BS_RDATA: begin
            if (byte_done) begin
              ptr_q    <= ptr_q + 1'b1;
              bus_q    <= BS_RACK;
              o_sda_oe <= 1'b0;
            end else begin
              o_sda_oe <= ~shreg_q[3'(4'h7 - bitcnt_q)];
            end
          end
          default: o_sda_oe <= 1'b0;
        endcase
      end
    end
  end

endmodule

// ---- verification/fa_supervisor_sva.sv ----
// Port-level checks of the fault alert supervisor.
`timescale 1ns/1ps
module fa_supervisor_sva
  import fa_pkg::*;
#(
  parameter int unsigned ILIM_CYC = LDO_ILIM_CYC,
  parameter int unsigned OFF_CYC  = LDO_OFF_CYC
) (
  input wire logic     i_clk,
  input wire logic     i_arst_n,
  input wire fa_pins_s i_pins,
  input wire logic     o_fault_alert_oe,
  input wire logic     o_aux_ldo_off,
  input wire logic     o_conv_stop,
  input wire logic     o_standby_state
);
  int         ilim_cnt;
  int         off_cnt;
  logic [5:0] lvl_h;
  logic [5:0] uv_h;
  wire  logic lvl;

  assign lvl = i_pins.wdt_expired | i_pins.thermal_over | i_pins.vin_ov
             | i_pins.vin_uv | i_pins.ldo_uv | i_pins.ldo_ilim;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ilim_cnt <= 0;
      off_cnt  <= 0;
      lvl_h    <= '0;
      uv_h     <= '0;
    end else begin
      ilim_cnt <= i_pins.ldo_ilim ? ilim_cnt + 1 : 0;
      off_cnt  <= o_aux_ldo_off ? off_cnt + 1 : 0;
      lvl_h    <= {lvl_h[4:0], lvl};
      uv_h     <= {uv_h[4:0], i_pins.ldo_uv};
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  AST_RST_STBY: assert property ($rose(i_arst_n) |-> o_standby_state)
    else $error("not in standby after reset");
  AST_POWER_ON: assert property (i_pins.en [*6] |-> !o_standby_state)
    else $error("stuck in standby");
  AST_STBY_BACK: assert property (!i_pins.en [*6] |-> o_standby_state)
    else $error("not back in standby");
  AST_FALL_WRITE: assert property ($fell(o_fault_alert_oe) |-> !i_pins.scl)
    else $error("alert fell outside a write");
  AST_LEVEL_HOLD: assert property ($fell(o_fault_alert_oe) |-> lvl_h == '0)
    else $error("alert fell with a level on");
  AST_LDO_HOLD: assert property ($fell(o_fault_alert_oe) |-> !o_aux_ldo_off)
    else $error("alert fell in LDO off wait");
  AST_LDO_TRIP: assert property (
    ilim_cnt == ILIM_CYC + 3 |-> ##[0:3] o_aux_ldo_off)
    else $error("LDO not shut off in time");
  AST_LDO_RETRY: assert property (off_cnt <= OFF_CYC + 2)
    else $error("LDO off wait too long");
  AST_LDO_OFF_MIN: assert property (
    $rose(o_aux_ldo_off) |-> o_aux_ldo_off [*8])
    else $error("LDO off wait too short");
  AST_CONV_CAUSE: assert property (o_conv_stop |-> o_aux_ldo_off ||
    $past(o_aux_ldo_off) || uv_h != '0 || ilim_cnt >= ILIM_CYC)
    else $error("stop without LDO fault");
endmodule

bind fa_supervisor fa_supervisor_sva #(
  .ILIM_CYC (ILIM_CYC),
  .OFF_CYC  (OFF_CYC)
) u_sva (
  .i_clk            (i_clk),
  .i_arst_n         (i_arst_n),
  .i_pins           (i_pins),
  .o_fault_alert_oe (o_fault_alert_oe),
  .o_aux_ldo_off    (o_aux_ldo_off),
  .o_conv_stop      (o_conv_stop),
  .o_standby_state  (o_standby_state)
);

// ---- verification/fa_host_model.sv ----
// Host model: bit-level serial bus master for register access.
`timescale 1ns/1ps
module fa_host_model
  import fa_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic dr(input logic c, input logic d, input int n);
    o_scl = c;
    o_sda = d;
    repeat (n) @(negedge i_clk);
  endtask
  task automatic bt(input logic b, output logic r);
    dr(1'b0, b, 4);
    dr(1'b1, b, 6);
    r = i_sda;
    dr(1'b1, b, 2);
    dr(1'b0, b, 4);
  endtask
  task automatic st();
    dr(1'b0, 1'b1, 4);
    dr(1'b1, 1'b1, 8);
    dr(1'b1, 1'b0, 8);
    dr(1'b0, 1'b0, 4);
  endtask
  task automatic sp();
    dr(1'b0, 1'b0, 4);
    dr(1'b1, 1'b0, 8);
    dr(1'b1, 1'b1, 8);
  endtask
  task automatic by(input logic [7:0] d, input logic h,
                    output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(h, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic nk);
    logic [7:0] q;
    logic [2:0] a;
    st();
    by({BUS_ADDR_DEFAULT, 1'b0}, 1'b1, q, a[0]);
    by(p, 1'b1, q, a[1]);
    by(d, 1'b1, q, a[2]);
    sp();
    nk = |a;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic       a;
    st();
    by({BUS_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
    by(p, 1'b1, q, a);
    st();
    by({BUS_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
    by(8'hFF, 1'b1, d, a);
    sp();
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the fault alert supervisor.
`timescale 1ns/1ps
module tb
  import fa_pkg::*;
;
  logic       clk;
  logic       rst_n;
  fa_pins_s   pn;
  fa_pins_s   pins;
  logic       scl;
  logic       hsda;
  logic       sda_oe;
  logic       alt;
  logic       off;
  logic       src;
  logic       stop;
  logic       stby;
  logic       skip;
  logic [4:0] vs;
  logic [3:0] obs;
  int         n_errors;
  int         num_checks;

  always_comb begin
    pins     = pn;
    pins.scl = scl;
    pins.sda = hsda & ~sda_oe;
  end
  assign obs = {alt, stby, off, stop};

  fa_supervisor #(.ILIM_CYC(20), .OFF_CYC(50), .TMO_CYC(2000)) uut (
    .i_clk(clk), .i_arst_n(rst_n), .i_pins(pins), .o_sda_oe(sda_oe),
    .o_fault_alert_oe(alt), .o_aux_ldo_off(off), .o_ldo_src_vin(src),
    .o_conv_stop(stop), .o_standby_state(stby), .o_skip_mode_off(skip),
    .o_ldo_vsel(vs));
  fa_host_model u_host (.i_clk(clk), .i_sda(pins.sda), .o_scl(scl),
    .o_sda(hsda));

  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wv(input int k, input logic v, input int n);
    for (int i = 0; i < n && obs[k] !== v; i++) @(negedge clk);
    cb(obs[k], v);
    if (obs[k] !== v) results();
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic nk;
    u_host.wr(p, d, nk);
    cb(nk, 1'b0);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    u_host.rd(p, q);
    chk(q, e);
  endtask
  task automatic clr();
    wr(OFF_FAULT_FLAGS, 8'h80);
  endtask
  task automatic setp(input int s, input logic v);
    case (s)
      SRC_WATCHDOG: pn.wdt_expired = v;
      SRC_THERMAL: pn.thermal_over = v;
      SRC_ADC_DONE: pn.adc_done = v;
      SRC_VIN_OV: pn.vin_ov = v;
      SRC_VIN_UV: pn.vin_uv = v;
      SRC_LIGHT_LOAD: pn.light_load_off_state = v;
      default: pn.hiccup_state = v;
    endcase
  endtask

  task automatic t_regs();
    cb(stby, 1'b1);
    cb(alt, 1'b0);
    chk({3'h0, vs}, RST_LDO_VOLTAGE);
    rd(OFF_LDO_VOLTAGE, RST_LDO_VOLTAGE);
    rd(OFF_ALERT_MASK_C, RST_ALERT_MASK);
    clr();
    rd(OFF_FAULT_FLAGS, 8'h00);
    wr(OFF_LDO_VOLTAGE, 8'h1F);
    chk({3'h0, vs}, 8'h1F);
    wr(OFF_CONV_OPTIONS, 8'h01);
    cb(skip, 1'b1);
    rd(8'h30, 8'h00);
  endtask
  task automatic t_level();
    int         lv[4] = '{SRC_WATCHDOG, SRC_THERMAL, SRC_VIN_OV, SRC_VIN_UV};
    logic [7:0] m;
    for (int k = 0; k < 4; k++) begin
      m = OFF_ALERT_MASK_A + 8'(lv[k] / 4);
      wr(m, 8'(1 << (lv[k] % 4)));
      setp(lv[k], 1'b1);
      cyc(10);
      cb(alt, 1'b0);
      setp(lv[k], 1'b0);
      cyc(10);
      clr();
      wr(m, 8'h00);
      setp(lv[k], 1'b1);
      wv(3, 1'b1, 10);
      clr();
      cb(alt, 1'b1);
      setp(lv[k], 1'b0);
      cyc(10);
      cb(alt, 1'b1);
      clr();
      cb(alt, 1'b0);
    end
    rd(OFF_FAULT_FLAGS, 8'h02);
    rd(OFF_FAULT_FLAGS, 8'h00);
  endtask
  task automatic t_edge();
    int ev[3] = '{SRC_ADC_DONE, SRC_LIGHT_LOAD, SRC_HICCUP};
    setp(SRC_ADC_DONE, 1'b1);
    cyc(10);
    cb(alt, 1'b0);
    setp(SRC_ADC_DONE, 1'b0);
    pn.adc_enabled = 1'b1;
    for (int k = 0; k < 3; k++) begin
      cyc(5);
      setp(ev[k], 1'b1);
      wv(3, 1'b1, 10);
      clr();
      cb(alt, 1'b0);
      setp(ev[k], 1'b0);
    end
  endtask
  task automatic t_power();
    pn.en = 1'b1;
    wv(2, 1'b0, 10);
    pn.en = 1'b0;
    wv(3, 1'b1, 10);
    clr();
    cb(alt, 1'b0);
    pn.en = 1'b1;
    wv(2, 1'b0, 10);
    pn.fet_oc = 1'b1;
    wv(3, 1'b1, 10);
    pn.fet_oc = 1'b0;
    clr();
    cb(alt, 1'b1);
    pn.en = 1'b0;
    wv(2, 1'b1, 10);
    clr();
    cb(alt, 1'b0);
  endtask
  task automatic t_ldo();
    pn.ldo_ilim = 1'b1;
    wv(1, 1'b1, 40);
    cb(stop, 1'b1);
    cb(alt, 1'b1);
    wv(1, 1'b0, 80);
    wv(1, 1'b1, 40);
    wr(OFF_CONV_OPTIONS, 8'h02);
    cb(stop, 1'b0);
    pn.ldo_ilim = 1'b0;
    wv(1, 1'b0, 80);
    wr(OFF_CONV_OPTIONS, 8'h00);
    pn.ldo_uv = 1'b1;
    wv(0, 1'b1, 10);
    rd(OFF_FAULT_FLAGS, 8'h01);
    pn.ldo_uv = 1'b0;
    wv(0, 1'b0, 10);
    clr();
    cb(alt, 1'b0);
  endtask
  task automatic t_src();
    logic [7:0] tb_l[6] = '{8'h00, 8'h05, 8'h03, 8'h06, 8'h44, 8'hC1};
    for (int k = 0; k < 6; k++) begin
      wr(OFF_LDO_SOURCE, {6'h00, tb_l[k][7:6]});
      pn.vin_lower = tb_l[k][2];
      pn.low_headroom = tb_l[k][1];
      cyc(6);
      cb(src, tb_l[k][0]);
    end
  endtask
  task automatic t_tmo();
    logic q;
    u_host.st();
    for (int i = 6; i >= 0; i--) u_host.bt(BUS_ADDR_DEFAULT[i], q);
    u_host.bt(1'b0, q);
    cyc(1750);
    cb(alt, 1'b0);
    cyc(200);
    cb(alt, 1'b1);
    cb(sda_oe, 1'b0);
    u_host.sp();
    rd(OFF_LDO_VOLTAGE, 8'h1F);
    clr();
    cb(alt, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    pn = '0;
    n_errors = 0;
    num_checks = 0;
    cyc(4);
    rst_n = 1'b1;
    cyc(4);
    t_regs();
    t_level();
    t_edge();
    t_power();
    t_ldo();
    t_src();
    t_tmo();
    results();
  end
endmodule
